// File: inc/codec_link_pkg.sv
// Package for the codec link status, modem slot and queue level block.
// Assumes a 250 MHz APB clock and an AC-link bit clock far slower than it.
package codec_link_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_LINK_STATUS = 8'h24;  // Codec link status, RO
  localparam logic [7:0] OFF_MODEM_OUT   = 8'h28;  // Modem slot out control, RW
  localparam logic [7:0] OFF_MODEM_IN    = 8'h2c;  // Modem slot in status, RO
  localparam logic [7:0] OFF_QUEUE       = 8'h30;  // Queue level and purge
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h40;  // Sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h44;  // Event mask, RW

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_CODEC_READY = 24;  // Link status: codec ready
  localparam int BIT_READ_VALID  = 23;  // Link status: read result valid
  localparam int BIT_MODEM_REQ   = 20;  // Modem out: send request
  localparam int BIT_RX_PURGE    = 31;  // Queue: purge receive side
  localparam int BIT_TX_PURGE    = 30;  // Queue: purge transmit side
  localparam int IRQ_MODEM_IN    = 0;   // Event: modem status updated
  localparam int IRQ_READ_DONE   = 1;   // Event: codec read data returned
  localparam int IRQ_READY_RISE  = 2;   // Event: codec became ready
  localparam int IRQ_BITS        = 3;   // Number of event bits

  // ----------------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------------
  localparam logic [31:0]         RST_REG      = 32'h0000_0000;
  localparam logic [IRQ_BITS-1:0] RST_IRQ      = 3'h0;
  localparam logic [7:0]          TX_CAPACITY  = 8'h80;  // Transmit queue size, bytes

  // ----------------------------------------------------------------------
  // AC-link frame layout
  // ----------------------------------------------------------------------
  localparam logic [3:0] SLOT_TAG     = 4'h0;   // Tag slot
  localparam logic [3:0] SLOT_ADDR    = 4'h1;   // Command address slot
  localparam logic [3:0] SLOT_DATA    = 4'h2;   // Command data slot
  localparam logic [3:0] SLOT_MODEM   = 4'hc;   // Modem GPIO slot, last of frame
  localparam logic [4:0] TAG_LAST     = 5'h0f;  // Last bit position of tag slot
  localparam logic [4:0] SLOT_LAST    = 5'h13;  // Last bit position of data slots
  localparam int         TAG_FRAME_OK = 15;     // Tag: frame valid / codec ready
  localparam int         TAG_ADDR_OK  = 14;     // Tag: slot 1 valid
  localparam int         TAG_DATA_OK  = 13;     // Tag: slot 2 valid
  localparam int         TAG_MODEM_OK = 3;      // Tag: slot 12 valid

  // Codec register command from the command register logic
  typedef struct packed {
    logic       rd;      // One for read, zero for write
    logic [6:0] index;   // Codec register index
    logic [15:0] wdata;  // Write data, ignored on read
  } codec_cmd_t;

  // Queue levels reported by the data queues
  typedef struct packed {
    logic [7:0] rx_used;  // Bytes held in receive queue
    logic [7:0] tx_free;  // Free bytes in transmit queue
  } queue_level_t;

endpackage : codec_link_pkg

// File: src/codec_link_status.sv
// Status, modem slot and queue level registers of an AC-link controller.
// Assumes an APB master on pclk, a codec bit clock and serial input from
// the pins, and command requests and queue levels from logic on pclk.
`timescale 1ns/1ps

// Function
// - Status bit 24 shows latest frame codec ready
// - New read request clears read valid flag, unless read data returns in the same cycle
// - Returned read data sets read valid flag
// - Bits 22-16 hold codec echoed index
// - Bits 15-0 hold last valid read data
// - Modem request bit sends slot 12 next
// - Modem request bit self clears after sending
// - Modem status captures valid slot 12 input
// - Modem status update raises an interrupt
// - Writing bit 31 purges receive queue
// - Writing bit 30 purges transmit queue
// - Bits 15-8 report receive bytes held
// - Bits 7-0 report transmit free bytes
// - Command request sends slot 1 next, and slot 2 for writes only
module codec_link_status (
  input  wire logic                         pclk,          // APB clock
  input  wire logic                         presetn,       // Async reset
  input  wire logic                         psel,          // APB select
  input  wire logic                         penable,       // APB access phase
  input  wire logic                         pwrite,        // APB direction
  input  wire logic [7:0]                   paddr,         // APB byte address
  input  wire logic [31:0]                  pwdata,        // APB write data
  output logic      [31:0]                  prdata,        // APB read data
  output logic                              pready,        // APB ready
  output logic                              pslverr,       // APB error
  input  wire logic                         cmd_req,       // Command request pulse
  input  wire codec_link_pkg::codec_cmd_t   cmd,           // Command fields
  input  wire codec_link_pkg::queue_level_t queue_level,   // Queue levels
  output logic                              rx_purge,      // Receive purge pulse
  output logic                              tx_purge,      // Transmit purge pulse
  output logic                              cmd_sent,      // Command slots sent pulse
  output logic                              irq,           // Level interrupt
  input  wire logic                         ac_bit_clk,    // Codec bit clock pin
  input  wire logic                         ac_sdata_in,   // Codec serial input pin
  output logic                              ac_sync,       // Frame sync pin
  output logic                              ac_sdata_out   // Serial output pin
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] bclk_sync;   // Bit clock, two stages
  logic [1:0] sdin_sync;   // Serial input, two stages
  logic       bclk_prev;   // Last synced bit clock, for edges

  // Only the second stage feeds any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_sync <= 2'h0;
      sdin_sync <= 2'h0;
      bclk_prev <= 1'b0;
    end else begin
      bclk_sync <= {bclk_sync[0], ac_bit_clk};
      sdin_sync <= {sdin_sync[0], ac_sdata_in};
      bclk_prev <= bclk_sync[1];
    end
  end

  logic bclk_rise;  // Drive edge of the link
  logic bclk_fall;  // Sample edge of the link
  assign bclk_rise = bclk_sync[1] & ~bclk_prev;
  assign bclk_fall = ~bclk_sync[1] & bclk_prev;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [3:0]  slot,         next_slot;          // Slot being transferred
  logic [4:0]  pos,          next_pos;           // Bit position in slot
  logic [19:0] rx_shift,     next_rx_shift;      // Incoming bits of slot
  logic [15:0] rx_tag,       next_rx_tag;        // Tag of frame in flight
  logic [6:0]  rx_addr,      next_rx_addr;       // Echoed index candidate
  logic        codec_ready,  next_codec_ready;   // Latest tag ready bit
  logic        read_valid,   next_read_valid;    // Read result valid
  logic        read_wait,    next_read_wait;     // Read sent, answer due
  logic [6:0]  echo_index,   next_echo_index;    // Echoed index
  logic [15:0] read_data,    next_read_data;     // Last read data
  logic        cmd_pend,     next_cmd_pend;      // Command awaits a frame
  codec_link_pkg::codec_cmd_t cmd_hold, next_cmd_hold;  // Pending command
  codec_link_pkg::codec_cmd_t cmd_frm,  next_cmd_frm;   // Command in frame
  logic        send_cmd,     next_send_cmd;      // Frame carries command
  logic        send_modem,   next_send_modem;    // Frame carries modem word
  logic        modem_req,    next_modem_req;     // Modem send request
  logic [19:0] modem_word,   next_modem_word;    // Modem control word
  logic [19:0] modem_frm,    next_modem_frm;     // Modem word in frame
  logic [19:0] modem_in,     next_modem_in;      // Captured modem status
  logic [2:0]  irq_stat,     next_irq_stat;      // Sticky events
  logic [2:0]  irq_mask,     next_irq_mask;      // Event enables
  logic [31:0] next_prdata;                      // Read data to register
  logic        next_pready, next_pslverr;        // Bus answer
  logic        next_rx_purge, next_tx_purge;     // Purge pulses
  logic        next_cmd_sent, next_irq;          // Event outputs
  logic        next_sync, next_sdout;            // Link outputs

  // Slot end position: the tag slot is shorter
  function automatic logic [4:0] slot_end(input logic [3:0] s);
    slot_end = (s == codec_link_pkg::SLOT_TAG) ? codec_link_pkg::TAG_LAST
                                               : codec_link_pkg::SLOT_LAST;
  endfunction : slot_end

  // Outgoing word of a slot, left aligned in 20 bits
  function automatic logic [19:0] tx_word(input logic [3:0] s,
                                          input logic sc, input logic sm,
                                          input codec_link_pkg::codec_cmd_t c,
                                          input logic [19:0] mw);
    logic [15:0] tag;
    tag = 16'h0000;
    tag[codec_link_pkg::TAG_FRAME_OK] = sc | sm;
    tag[codec_link_pkg::TAG_ADDR_OK]  = sc;
    tag[codec_link_pkg::TAG_DATA_OK]  = sc & ~c.rd;
    tag[codec_link_pkg::TAG_MODEM_OK] = sm;
    if (s == codec_link_pkg::SLOT_TAG) begin
      tx_word = {tag, 4'h0};
    end else if (s == codec_link_pkg::SLOT_ADDR && sc) begin
      tx_word = {c.rd, c.index, 12'h000};
    end else if (s == codec_link_pkg::SLOT_DATA && sc && !c.rd) begin
      tx_word = {c.wdata, 4'h0};
    end else if (s == codec_link_pkg::SLOT_MODEM && sm) begin
      tx_word = mw;
    end else begin
      tx_word = 20'h00000;
    end
  endfunction : tx_word

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic        acc;      // Access phase seen this cycle
  logic        wr_ok;    // Write takes effect now
  logic [19:0] rx_word;  // Slot word completed this fall
  logic [15:0] tag_now;  // Tag completed this fall
  logic [4:0]  send_idx; // Bit index within tx word
  logic [19:0] tx_now;   // Outgoing word of the slot in flight

  always_comb begin
    acc       = psel & penable & ~pready;
    wr_ok     = psel & penable & pready & pwrite;
    rx_word   = {rx_shift[18:0], sdin_sync[1]};
    tag_now   = rx_word[15:0];
    send_idx  = codec_link_pkg::SLOT_LAST - pos;
    tx_now    = tx_word(slot, send_cmd, send_modem, cmd_frm, modem_frm);
    next_slot        = slot;
    next_pos         = pos;
    next_rx_shift    = rx_shift;
    next_rx_tag      = rx_tag;
    next_rx_addr     = rx_addr;
    next_codec_ready = codec_ready;
    next_read_valid  = read_valid;
    next_read_wait   = read_wait;
    next_echo_index  = echo_index;
    next_read_data   = read_data;
    next_cmd_pend    = cmd_pend;
    next_cmd_hold    = cmd_hold;
    next_cmd_frm     = cmd_frm;
    next_send_cmd    = send_cmd;
    next_send_modem  = send_modem;
    next_modem_req   = modem_req;
    next_modem_word  = modem_word;
    next_modem_frm   = modem_frm;
    next_modem_in    = modem_in;
    next_irq_stat    = irq_stat;
    // Write one to clear first, so that an event below still sets
    if (wr_ok && paddr == codec_link_pkg::OFF_IRQ_STATUS) begin
      next_irq_stat = irq_stat & ~pwdata[2:0];
    end
    next_irq_mask    = irq_mask;
    next_sync        = ac_sync;
    next_sdout       = ac_sdata_out;
    next_cmd_sent    = 1'b0;
    next_rx_purge    = 1'b0;
    next_tx_purge    = 1'b0;

    // Command request from the command register logic
    if (cmd_req) begin
      next_cmd_pend = 1'b1;
      next_cmd_hold = cmd;
      if (cmd.rd) begin
        next_read_valid = 1'b0;
      end
    end

    // Drive edge: frame start latches what this frame carries
    if (bclk_rise) begin
      if (slot == codec_link_pkg::SLOT_TAG && pos == 5'h00) begin
        next_send_cmd   = cmd_pend;
        next_cmd_frm    = cmd_hold;
        next_cmd_pend   = cmd_req;
        next_send_modem = modem_req;
        next_modem_frm  = modem_word;
        next_sdout = cmd_pend | modem_req;
      end else begin
        next_sdout = tx_now[send_idx];
      end
      next_sync = (slot == codec_link_pkg::SLOT_TAG);
    end

    // Sample edge: shift in, act on slot ends, advance position
    if (bclk_fall) begin
      next_rx_shift = rx_word;
      if (pos == slot_end(slot)) begin
        next_pos = 5'h00;
        unique case (slot)
          codec_link_pkg::SLOT_TAG: begin
            next_rx_tag      = tag_now;
            next_codec_ready = tag_now[codec_link_pkg::TAG_FRAME_OK];
            if (tag_now[codec_link_pkg::TAG_FRAME_OK] && !codec_ready) begin
              next_irq_stat[codec_link_pkg::IRQ_READY_RISE] = 1'b1;
            end
          end
          codec_link_pkg::SLOT_ADDR: begin
            next_rx_addr = rx_word[18:12];
          end
          codec_link_pkg::SLOT_DATA: begin
            // Read answer comes the frame after the request
            if (read_wait && rx_tag[codec_link_pkg::TAG_ADDR_OK]
                && rx_tag[codec_link_pkg::TAG_DATA_OK]) begin
              next_read_valid = 1'b1;
              next_echo_index = rx_addr;
              next_read_data  = rx_word[19:4];
              next_read_wait  = 1'b0;
              next_irq_stat[codec_link_pkg::IRQ_READ_DONE] = 1'b1;
            end
            if (send_cmd) begin
              next_read_wait = cmd_frm.rd;
              next_cmd_sent  = 1'b1;
            end
          end
          codec_link_pkg::SLOT_MODEM: begin
            if (rx_tag[codec_link_pkg::TAG_MODEM_OK]) begin
              next_modem_in = rx_word;
              next_irq_stat[codec_link_pkg::IRQ_MODEM_IN] = 1'b1;
            end
            if (send_modem) begin
              next_modem_req = 1'b0;
            end
            next_send_cmd   = 1'b0;
            next_send_modem = 1'b0;
          end
          default: begin
          end
        endcase
        next_slot = (slot == codec_link_pkg::SLOT_MODEM) ? codec_link_pkg::SLOT_TAG
                                                          : slot + 4'h1;
      end else begin
        next_pos = pos + 5'h01;
      end
    end

    // Register writes; a software set beats the self clear
    if (wr_ok) begin
      unique case (paddr)
        codec_link_pkg::OFF_MODEM_OUT: begin
          next_modem_word = pwdata[19:0];
          if (pwdata[codec_link_pkg::BIT_MODEM_REQ]) begin
            next_modem_req = 1'b1;
          end
        end
        codec_link_pkg::OFF_QUEUE: begin
          next_rx_purge = pwdata[codec_link_pkg::BIT_RX_PURGE];
          next_tx_purge = pwdata[codec_link_pkg::BIT_TX_PURGE];
        end
        codec_link_pkg::OFF_IRQ_MASK: begin
          next_irq_mask = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // Bus answer: one wait state, data and error registered with ready
    next_pready  = acc;
    next_pslverr = 1'b0;
    next_prdata  = codec_link_pkg::RST_REG;
    if (acc) begin
      unique case (paddr)
        codec_link_pkg::OFF_LINK_STATUS: begin
          next_prdata = {7'h00, codec_ready, read_valid,
                         echo_index, read_data};
        end
        codec_link_pkg::OFF_MODEM_OUT: begin
          next_prdata = {11'h000, modem_req, modem_word};
        end
        codec_link_pkg::OFF_MODEM_IN: begin
          next_prdata = {12'h000, modem_in};
        end
        codec_link_pkg::OFF_QUEUE: begin
          // Purge bits read zero; a purge in flight reads empty and full
          next_prdata[15:8] = rx_purge ? 8'h00 : queue_level.rx_used;
          next_prdata[7:0]  = tx_purge ? codec_link_pkg::TX_CAPACITY
                                       : queue_level.tx_free;
        end
        codec_link_pkg::OFF_IRQ_STATUS: begin
          next_prdata = {29'h0, irq_stat};
        end
        codec_link_pkg::OFF_IRQ_MASK: begin
          next_prdata = {29'h0, irq_mask};
        end
        default: begin
          next_pslverr = 1'b1;   // Unmapped address
        end
      endcase
    end

    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot         <= codec_link_pkg::SLOT_TAG;
      pos          <= 5'h00;
      rx_shift     <= 20'h00000;
      rx_tag       <= 16'h0000;
      rx_addr      <= 7'h00;
      codec_ready  <= 1'b0;
      read_valid   <= 1'b0;
      read_wait    <= 1'b0;
      echo_index   <= 7'h00;
      read_data    <= 16'h0000;
      cmd_pend     <= 1'b0;
      cmd_hold     <= '0;
      cmd_frm      <= '0;
      send_cmd     <= 1'b0;
      send_modem   <= 1'b0;
      modem_req    <= 1'b0;
      modem_word   <= 20'h00000;
      modem_frm    <= 20'h00000;
      modem_in     <= 20'h00000;
      irq_stat     <= codec_link_pkg::RST_IRQ;
      irq_mask     <= codec_link_pkg::RST_IRQ;
      prdata       <= codec_link_pkg::RST_REG;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      rx_purge     <= 1'b0;
      tx_purge     <= 1'b0;
      cmd_sent     <= 1'b0;
      irq          <= 1'b0;
      ac_sync      <= 1'b0;
      ac_sdata_out <= 1'b0;
    end else begin
      slot         <= next_slot;
      pos          <= next_pos;
      rx_shift     <= next_rx_shift;
      rx_tag       <= next_rx_tag;
      rx_addr      <= next_rx_addr;
      codec_ready  <= next_codec_ready;
      read_valid   <= next_read_valid;
      read_wait    <= next_read_wait;
      echo_index   <= next_echo_index;
      read_data    <= next_read_data;
      cmd_pend     <= next_cmd_pend;
      cmd_hold     <= next_cmd_hold;
      cmd_frm      <= next_cmd_frm;
      send_cmd     <= next_send_cmd;
      send_modem   <= next_send_modem;
      modem_req    <= next_modem_req;
      modem_word   <= next_modem_word;
      modem_frm    <= next_modem_frm;
      modem_in     <= next_modem_in;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      rx_purge     <= next_rx_purge;
      tx_purge     <= next_tx_purge;
      cmd_sent     <= next_cmd_sent;
      irq          <= next_irq;
      ac_sync      <= next_sync;
      ac_sdata_out <= next_sdout;
    end
  end

endmodule : codec_link_status

// File: dv/codec_link_checker_assertions.sv
// Checker of the codec link status block, bound to every instance.
// Sees only the block's ports; all properties run on pclk.
`timescale 1ns/1ps
module codec_link_checker (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [7:0]                   paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire codec_link_pkg::queue_level_t queue_level,
  input wire logic                         rx_purge,
  input wire logic                         tx_purge,
  input wire logic                         cmd_sent
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfers, seen at the edge that samples pready
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic rd_done = psel && penable && pready && !pwrite;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_rx_purge_src: assert property (
    rx_purge |-> $past(wr_done && paddr == 8'h30 && pwdata[31]))
    else $error("receive purge without a purge write");
  a_tx_purge_src: assert property (
    tx_purge |-> $past(wr_done && paddr == 8'h30 && pwdata[30]))
    else $error("transmit purge without a purge write");
  a_purge_pulse: assert property (
    (rx_purge || tx_purge) |=> !rx_purge && !tx_purge)
    else $error("purge pulse longer than one cycle");
  a_queue_read: assert property (
    rd_done && paddr == 8'h30 && !$past(rx_purge || tx_purge)
    |-> prdata == {16'h0, $past(queue_level)}) else $error("queue level read wrong");
  a_status_rsvd: assert property (
    rd_done && paddr == 8'h24 |-> prdata[31:25] == 7'h0) else $error("status reserved set");
  a_modem_rsvd: assert property (
    rd_done && paddr == 8'h2c |-> prdata[31:20] == 12'h0) else $error("modem reserved set");
  a_unmapped_zero: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("error response not clean");
  a_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("access not answered in one wait");
  a_cmd_pulse: assert property (
    cmd_sent |=> !cmd_sent) else $error("command sent pulse too long");
endmodule : codec_link_checker

bind codec_link_status codec_link_checker u_codec_link_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .queue_level, .rx_purge, .tx_purge, .cmd_sent);

// File: dv/codec_link_model.sv
// Codec model: free running bit clock, 256 bit frames, MSB first.
// Assumes the block counts frames from its first bit clock rise.
`timescale 1ns/1ps
module codec_link_model (
  input  wire logic        presetn,
  input  wire logic        ready,
  input  wire logic [19:0] mstat,
  input  wire logic [15:0] rdata,
  input  wire logic        ac_sdata_out,
  output logic             ac_bit_clk,
  output logic             ac_sdata_in,
  output logic [19:0]      out_modem,
  output int               frames
);
  logic [7:0]   pos;   // Next bit of frame
  logic [6:0]   echo;  // Index of last command sent, read or write
  logic [15:0]  tag;   // Outgoing tag
  logic [19:0]  sh;    // Outgoing shifter
  logic [255:0] fr;    // Incoming frame, slots 1, 2 and 12 always valid
  assign fr = {ready, 2'b11, 9'h0, 1'b1, 3'h0, 1'b0, echo, 12'h0, rdata, 184'h0, mstat};
  // Phase offset keeps the bit clock unrelated to pclk
  initial begin
    {ac_bit_clk, ac_sdata_in, pos, echo, frames} = '0;
    #37;
    forever #80 ac_bit_clk = ~ac_bit_clk;
  end
  // Drive at rise so the line is stable at the sampling fall
  always @(posedge ac_bit_clk or negedge presetn) begin
    if (!presetn) begin
      pos <= 8'h0;
      ac_sdata_in <= 1'b0;
    end else begin
      ac_sdata_in <= fr[8'hff - pos];
      pos <= pos + 8'h1;
      if (pos == 8'hff) frames <= frames + 1;
    end
  end
  // Capture outgoing tag, command index and modem word at falls
  always @(negedge ac_bit_clk) begin
    sh <= {sh[18:0], ac_sdata_out};
    if (pos == 8'd16) tag <= {sh[14:0], ac_sdata_out};
    if (pos == 8'd36 && tag[14]) echo <= sh[17:11];
    if (pos == 8'd0 && tag[3]) out_modem <= {sh[18:0], ac_sdata_out};
  end
endmodule : codec_link_model

// File: dv/test_codec_link_status.sv
// Bench for the codec link status block with a behavioural codec.
// Assumes a 250 MHz pclk and a 160 ns codec bit clock.
`timescale 1ns/1ps
module test_codec_link_status;
  logic                         pclk, presetn, psel, penable, pwrite, cmd_req, ready;
  logic                         pready, pslverr, rx_purge, tx_purge, cmd_sent, irq, re;
  logic                         ac_bit_clk, ac_sdata_in, ac_sdata_out, ac_sync;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata, prdata, rv;
  logic [19:0]                  mstat, word, out_modem;
  logic [15:0]                  rdata;
  logic [6:0]                   idx;
  codec_link_pkg::codec_cmd_t   cmd;
  codec_link_pkg::queue_level_t queue_level;
  int                           seed, frames, miscompares, compares, rxp, txp;
  codec_link_status u_codec_link_status (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_req, .cmd, .queue_level, .rx_purge, .tx_purge, .cmd_sent, .irq,
    .ac_bit_clk, .ac_sdata_in, .ac_sync, .ac_sdata_out);
  codec_link_model u_codec_link_model (
    .presetn, .ready, .mstat, .rdata, .ac_sdata_out, .ac_bit_clk, .ac_sdata_in,
    .out_modem, .frames);
  always #2 pclk = ~pclk;
  // Purge pulse counters
  always @(posedge pclk) begin
    if (rx_purge === 1'b1) rxp++;
    if (tx_purge === 1'b1) txp++;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer, entered just after an edge; result in rv and re
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);  // Only the watchdog ends a hang
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_frames(input int k);
    int f0;
    f0 = frames;
    wait (frames >= f0 + k);
    repeat (60) @(posedge pclk);
  endtask : wait_frames
  function automatic logic [31:0] status_exp(input logic [6:0] i, input logic [15:0] d);
    return {7'h0, 2'b11, i, d};
  endfunction : status_exp
  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    #320000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, cmd_req, ready, paddr, pwdata} = '0;
    {cmd, queue_level, mstat, rdata, miscompares, compares, rxp, txp} = '0;
    seed = 82835;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h24, 32'h0);
    check("link status", 32'h0, rv);
    apb(1'b0, 8'h2c, 32'h0);
    check("modem status", 32'h0, rv);
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped error", 32'h1, re);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      queue_level <= (i == 0) ? 16'h0080 : 16'($random(seed));
      apb(1'b0, 8'h30, 32'h0);
      check("queue level", {16'h0, queue_level}, rv);
    end
    apb(1'b1, 8'h30, 32'h8000_0000);
    repeat (3) @(posedge pclk);
    check("rx purges", 32'h1, rxp);
    check("tx purges", 32'h0, txp);
    apb(1'b1, 8'h30, 32'h4000_0000);
    repeat (3) @(posedge pclk);
    check("tx purges", 32'h1, txp);
    apb(1'b0, 8'h30, 32'h0);
    check("queue after purge", {16'h0, queue_level}, rv);
    $display("test queue done");
    ready <= 1'b1;
    mstat <= 20'($random(seed));
    word = 20'($random(seed));
    apb(1'b1, 8'h28, {11'h0, 1'b1, word});
    apb(1'b0, 8'h28, 32'h0);
    check("modem control", {11'h0, 1'b1, word}, rv);
    for (int k = 0; k < 2; k++) begin
      idx = 7'($random(seed));
      rdata <= 16'($random(seed));
      cmd <= '{rd: 1'b1, index: idx, wdata: 16'h0};
      cmd_req <= 1'b1;
      @(posedge pclk);
      cmd_req <= 1'b0;
      apb(1'b0, 8'h24, 32'h0);
      check("read valid", 32'h0, rv[23]);
      wait_frames(3);
      check("frame sync", 32'h1, ac_sync);
      apb(1'b0, 8'h24, 32'h0);
      check("link status", status_exp(idx, rdata), rv);
      if (k == 0) $display("test read done");
    end
    check("modem slot out", word, out_modem);
    apb(1'b0, 8'h28, 32'h0);
    check("modem control", {12'h0, word}, rv);
    apb(1'b0, 8'h2c, 32'h0);
    check("modem status", {12'h0, mstat}, rv);
    apb(1'b0, 8'h40, 32'h0);
    check("events", 32'h7, rv);
    check("irq masked", 32'h0, irq);
    apb(1'b1, 8'h44, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq", 32'h1, irq);
    apb(1'b1, 8'h40, 32'h7);
    repeat (2) @(posedge pclk);
    check("irq cleared", 32'h0, irq);
    $display("test link done");
    give_verdict();
  end
endmodule : test_codec_link_status
